// ===== udbp_pkg.sv
package udbp_pkg;

	// clock and link timing
	localparam int CLK_NS   = 10;
	localparam int UDMA_MAX = 6;
	localparam int MW_MAX   = 4;

	// typical half of the two-cycle time per udma mode, ns
	localparam int HALF_NS0 = 120;
	localparam int HALF_NS1 = 80;
	localparam int HALF_NS2 = 60;
	localparam int HALF_NS3 = 45;
	localparam int HALF_NS4 = 30;
	localparam int HALF_NS5 = 20;
	localparam int HALF_NS6 = 15;

	// burst crc
	localparam logic [15:0] CRC_SEED = 16'h4ABA;
	localparam logic [15:0] CRC_POLY = 16'h1021;

	// transfer-mode subcommand codes
	localparam logic [4:0] XFER_UDMA = 5'h08;
	localparam logic [4:0] XFER_MWDMA = 5'h04;

	// interface modes
	localparam logic [1:0] IFM_MEM = 2'h0;
	localparam logic [1:0] IFM_IO  = 2'h1;
	localparam logic [1:0] IFM_IDE = 2'h2;

	// reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [6:0] UDMA_SUPPORTED = 7'h7F;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_REQ   = 5'b00010,
		ST_DIN   = 5'b00100,
		ST_DOUT  = 5'b01000,
		ST_CRC   = 5'b10000
	} udbp_state_t;

	// cycles for half a strobe period, least time rounded up
	function automatic logic [7:0] udbp_half_cyc(input logic [2:0] mode);
		int ns;
		case (mode)
			3'h0: ns = HALF_NS0;
			3'h1: ns = HALF_NS1;
			3'h2: ns = HALF_NS2;
			3'h3: ns = HALF_NS3;
			3'h4: ns = HALF_NS4;
			3'h5: ns = HALF_NS5;
			default: ns = HALF_NS6;
		endcase
		return 8'((ns + CLK_NS - 1) / CLK_NS);
	endfunction : udbp_half_cyc

endpackage : udbp_pkg

// ===== udbp_crc.sv
`timescale 1ns/1ps
`default_nettype none
module udbp_crc (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clear,
	input  wire logic        en,
	input  wire logic [15:0] data,
	output logic      [15:0] crc_r
);
	logic [15:0] crc_nxt;

	// bitwise crc step over one word, msb first
	always_comb
	begin
		crc_nxt = crc_r;
		for (int i = 15; i >= 0; i--)
		begin
			if (crc_nxt[15] ^ data[i])
				crc_nxt = (crc_nxt << 1) ^ udbp_pkg::CRC_POLY;
			else
				crc_nxt = crc_nxt << 1;
		end
	end

	// restart at seed per burst
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || clear)
			crc_r <= udbp_pkg::CRC_SEED;
		else if (en)
			crc_r <= crc_nxt;
	end
endmodule : udbp_crc
`default_nettype wire

// ===== udbp_buf.sv
`timescale 1ns/1ps
`default_nettype none
module udbp_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [DEPTH-1:0] vld_r;
	logic [DEPTH-1:0] vld_nxt;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;
	assign out_valid = vld_r[0];
	assign out_data  = mem_r[0];

	// valid flags shift down on pop, fill first free slot on push
	always_comb
	begin
		vld_nxt = pop ? (vld_r >> 1) : vld_r;
		if (push)
			vld_nxt = {vld_nxt[DEPTH-2:0], 1'b1};
	end

	// ready registered so the filling side sees a flop
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			vld_r    <= '0;
			in_ready <= 1'b1;
		end
		else
		begin
			vld_r    <= vld_nxt;
			in_ready <= !vld_nxt[DEPTH-1];
		end
	end

	// storage shifts toward the head, new word lands behind last valid
	generate
		for (genvar g = 0; g < DEPTH; g++)
		begin : g_slot
			logic below;
			logic here;
			assign below = (g + 1 < DEPTH) ? vld_r[(g + 1) % DEPTH] : 1'b0;
			assign here  = pop ? !below && (g == 0 || vld_r[g]) : !vld_r[g]
				&& (g == 0 || vld_r[(g + DEPTH - 1) % DEPTH]);
			always_ff @(posedge core_clk)
			begin
				if (push && here)
					mem_r[g] <= in_data;
				else if (pop && below)
					mem_r[g] <= mem_r[(g + 1) % DEPTH];
			end
		end
	endgenerate
endmodule : udbp_buf
`default_nettype wire

// ===== udbp_port.sv
// Functional notes
// - burst needs udma, dma command, request, acknowledge
// - acknowledge negation restores normal pin meanings
// - data driver also drives its strobe
// - device owns bus on reads, host on writes
// - sender drives data, strobes after settling
// - both strobe edges carry one word
// - identify word reports udma support, modes
// - only one udma mode active, timing kept
// - every slower udma mode also accepted
// - revert disabled keeps mode over soft resets
// - revert enabled falls back to multiword
// - hardware reset clears udma selection
// - both ends crc every burst, host sends
// - crc mismatch recorded as error
// - only first crc error per command reported
// - crc error may abort, always reported
// - read burst: host ready, device strobe
// - write burst: host strobe, device ready
// - ide mode decodes only three address lines
// - request polarity per interface mode
// - stop strobes when ready negated, pause
`timescale 1ns/1ps
`default_nettype none
module udbp_port (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [1:0]  iface_mode,
	input  wire logic        host_attribute_select_line,
	input  wire logic        host_write_strobe_line,
	input  wire logic        host_output_enable_line,
	output logic             device_wait_line_o,
	output logic             device_wait_line_oe,
	input  wire logic [15:0] host_data_bus_i,
	output logic      [15:0] host_data_bus_o,
	output logic             host_data_bus_oe,
	input  wire logic [10:0] host_address_bus,
	output logic      [10:0] decoded_addr_r,
	output logic             input_acknowledge_pin_o,
	input  wire logic        input_acknowledge_pin_level,
	input  wire logic        feat_valid,
	input  wire logic [7:0]  feat_code,
	input  wire logic        revert_en_set,
	input  wire logic        revert_dis_set,
	input  wire logic        soft_reset,
	input  wire logic        cmd_start,
	input  wire logic        cmd_write,
	input  wire logic        cmd_done,
	input  wire logic        crc_abort_en,
	input  wire logic        tx_valid,
	input  wire logic [15:0] tx_data,
	output logic             tx_ready,
	output logic             rx_valid,
	output logic      [15:0] rx_data,
	input  wire logic        rx_ready,
	output logic             udma_sel_r,
	output logic      [2:0]  udma_mode_r,
	output logic             mwdma_sel_r,
	output logic      [2:0]  mwdma_mode_r,
	output logic             feat_reject_r,
	output logic      [15:0] id_udma_word_r,
	output logic             crc_err_r,
	output logic      [7:0]  crc_err_burst_r,
	output logic             cmd_abort_r,
	output logic             burst_active_r
);
	udbp_pkg::udbp_state_t state_r;
	logic        revert_en_r;
	logic        cmd_active_r;
	logic        cmd_wr_r;
	logic [7:0]  burst_cnt_r;
	// pin synchronisers, third stage only for edge detection
	logic [2:0]  ack_s;
	logic [1:0]  stop_s;
	logic [2:0]  hoe_s;
	logic [15:0] dat_s1;
	logic [15:0] dat_s2;
	logic        ack_on;
	logic        ack_off_edge;
	logic        hstrobe_edge;
	// sender side
	logic        have_word_r;
	logic [7:0]  hc_cnt_r;
	logic        tx_out_valid;
	logic [15:0] tx_out_data;
	logic        tx_pop;
	logic        strobe_go;
	// receiver side
	logic        rx_push_r;
	logic [15:0] rx_word_r;
	logic        rx_in_ready;
	logic        rx_has_word;
	// crc
	logic        crc_clear;
	logic        crc_en;
	logic [15:0] crc_word;
	logic [15:0] crc_val;
	logic [15:0] host_crc_r;
	logic        crc_bad;

	// two-flop synchronisers on every link input
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ack_s  <= 3'h7;
			stop_s <= 2'h0;
			hoe_s  <= 3'h7;
			dat_s1 <= 16'h0000;
			dat_s2 <= 16'h0000;
		end
		else
		begin
			ack_s  <= {ack_s[1:0], host_attribute_select_line};
			stop_s <= {stop_s[0], host_write_strobe_line};
			hoe_s  <= {hoe_s[1:0], host_output_enable_line};
			dat_s1 <= host_data_bus_i;
			dat_s2 <= dat_s1;
		end
	end

	// acknowledge is active low in all three interface modes
	assign ack_on       = !ack_s[1];
	assign ack_off_edge = ack_s[1] && !ack_s[2];
	assign hstrobe_edge = hoe_s[1] ^ hoe_s[2];

	// only the low three address lines in ide mode
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			decoded_addr_r <= 11'h000;
		else if (iface_mode == udbp_pkg::IFM_IDE)
			decoded_addr_r <= {8'h00, host_address_bus[2:0]};
		else
			decoded_addr_r <= host_address_bus;
	end

	// transfer mode selection and its survival over resets
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			udma_sel_r    <= 1'b0;
			udma_mode_r   <= udbp_pkg::MODE_RST;
			mwdma_sel_r   <= 1'b0;
			mwdma_mode_r  <= udbp_pkg::MODE_RST;
			revert_en_r   <= 1'b0;
			feat_reject_r <= 1'b0;
		end
		else
		begin
			feat_reject_r <= 1'b0;
			if (revert_en_set)
				revert_en_r <= 1'b1;
			else if (revert_dis_set)
				revert_en_r <= 1'b0;
			if (soft_reset && revert_en_r)
			begin
				udma_sel_r  <= 1'b0;
				mwdma_sel_r <= 1'b1;
			end
			else if (feat_valid)
			begin
				if (feat_code[7:3] == udbp_pkg::XFER_UDMA
					&& feat_code[2:0] <= 3'(udbp_pkg::UDMA_MAX))
				begin
					udma_sel_r  <= 1'b1;
					udma_mode_r <= feat_code[2:0];
					mwdma_sel_r <= 1'b0;
				end
				else if (feat_code[7:3] == udbp_pkg::XFER_MWDMA
					&& feat_code[2:0] <= 3'(udbp_pkg::MW_MAX))
				begin
					mwdma_sel_r  <= 1'b1;
					mwdma_mode_r <= feat_code[2:0];
					udma_sel_r   <= 1'b0;
				end
				else
					feat_reject_r <= 1'b1;
			end
		end
	end

	// identify word: selected mode one-hot over supported mask
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			id_udma_word_r <= {9'h000, udbp_pkg::UDMA_SUPPORTED};
		else
			id_udma_word_r <= {1'b0, udma_sel_r ? 7'(7'h01 << udma_mode_r) : 7'h00,
				1'b0, udbp_pkg::UDMA_SUPPORTED};
	end

	// command bookkeeping, abort on crc error when enabled
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cmd_active_r <= 1'b0;
			cmd_wr_r     <= 1'b0;
			cmd_abort_r  <= 1'b0;
		end
		else
		begin
			cmd_abort_r <= 1'b0;
			if (crc_bad && crc_abort_en)
			begin
				cmd_active_r <= 1'b0;
				cmd_abort_r  <= 1'b1;
			end
			else if (cmd_start)
			begin
				cmd_active_r <= 1'b1;
				cmd_wr_r     <= cmd_write;
			end
			else if (cmd_done)
				cmd_active_r <= 1'b0;
		end
	end

	// burst sequencing
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_r        <= udbp_pkg::ST_IDLE;
			burst_active_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				udbp_pkg::ST_IDLE:
					if (cmd_active_r && udma_sel_r)
						state_r <= udbp_pkg::ST_REQ;
				udbp_pkg::ST_REQ:
					if (!cmd_active_r || !udma_sel_r)
						state_r <= udbp_pkg::ST_IDLE;
					else if (ack_on)
					begin
						state_r <= cmd_wr_r ? udbp_pkg::ST_DOUT : udbp_pkg::ST_DIN;
						burst_active_r <= 1'b1;
					end
				udbp_pkg::ST_DIN, udbp_pkg::ST_DOUT:
					if (ack_off_edge)
					begin
						state_r        <= udbp_pkg::ST_CRC;
						burst_active_r <= 1'b0;
					end
				udbp_pkg::ST_CRC:
					state_r <= udbp_pkg::ST_IDLE;
				default:
					state_r <= udbp_pkg::ST_IDLE;
			endcase
		end
	end

	// request pin: active high in ide, active low in card modes
	// stop is only a stop inside a burst, outside it the line idles high
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			input_acknowledge_pin_o <= 1'b1;
		else if (!udma_sel_r)
			input_acknowledge_pin_o <= input_acknowledge_pin_level;
		else if ((state_r == udbp_pkg::ST_REQ || (burst_active_r && !stop_s[1]))
			&& cmd_active_r && !cmd_done)
			input_acknowledge_pin_o <= (iface_mode == udbp_pkg::IFM_IDE);
		else
			input_acknowledge_pin_o <= (iface_mode != udbp_pkg::IFM_IDE);
	end

	// sender: load word, wait settle time, then toggle strobe
	assign tx_pop    = !have_word_r && tx_out_valid && state_r == udbp_pkg::ST_DIN;
	assign strobe_go = have_word_r && hc_cnt_r == 8'h00 && !hoe_s[1]
		&& !stop_s[1] && state_r == udbp_pkg::ST_DIN;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || state_r != udbp_pkg::ST_DIN)
		begin
			have_word_r <= 1'b0;
			hc_cnt_r    <= 8'h00;
		end
		else if (tx_pop)
		begin
			have_word_r <= 1'b1;
			hc_cnt_r    <= udbp_pkg::udbp_half_cyc(udma_mode_r);
		end
		else if (have_word_r && hc_cnt_r != 8'h00)
			hc_cnt_r <= hc_cnt_r - 8'h01;
		else if (strobe_go)
			have_word_r <= 1'b0;
	end

	// pin drive: device strobe and data on reads, ready on writes
	// data bus freed on stop so the host can place its crc word
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			device_wait_line_o  <= 1'b1;
			device_wait_line_oe <= 1'b0;
			host_data_bus_o     <= 16'h0000;
			host_data_bus_oe    <= 1'b0;
		end
		else if (state_r == udbp_pkg::ST_DIN)
		begin
			device_wait_line_oe <= 1'b1;
			host_data_bus_oe    <= !stop_s[1];
			if (tx_pop)
				host_data_bus_o <= tx_out_data;
			if (strobe_go)
				device_wait_line_o <= !device_wait_line_o;
		end
		else if (state_r == udbp_pkg::ST_DOUT)
		begin
			device_wait_line_oe <= 1'b1;
			device_wait_line_o  <= rx_has_word;
			host_data_bus_oe    <= 1'b0;
		end
		else
		begin
			device_wait_line_o  <= 1'b1;
			device_wait_line_oe <= 1'b0;
			host_data_bus_oe    <= 1'b0;
		end
	end

	// receiver: capture a word on every host strobe edge
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rx_push_r <= 1'b0;
			rx_word_r <= 16'h0000;
		end
		else
		begin
			rx_push_r <= state_r == udbp_pkg::ST_DOUT && hstrobe_edge;
			if (state_r == udbp_pkg::ST_DOUT && hstrobe_edge)
				rx_word_r <= dat_s2;
		end
	end

	// host crc caught on acknowledge negation, compared after
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			host_crc_r <= 16'h0000;
		else if (burst_active_r && ack_off_edge)
			host_crc_r <= dat_s2;
	end

	assign crc_clear = state_r == udbp_pkg::ST_REQ && ack_on;
	assign crc_en    = strobe_go || rx_push_r;
	assign crc_word  = strobe_go ? host_data_bus_o : rx_word_r;
	assign crc_bad   = state_r == udbp_pkg::ST_CRC && host_crc_r != crc_val;

	// first crc error per command kept, error beats new command
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			crc_err_r       <= 1'b0;
			crc_err_burst_r <= 8'h00;
			burst_cnt_r     <= 8'h00;
		end
		else
		begin
			if (cmd_start)
				burst_cnt_r <= 8'h00;
			else if (state_r == udbp_pkg::ST_CRC)
				burst_cnt_r <= burst_cnt_r + 8'h01;
			if (crc_bad && !crc_err_r)
			begin
				crc_err_r       <= 1'b1;
				crc_err_burst_r <= burst_cnt_r;
			end
			else if (cmd_start && !crc_bad)
				crc_err_r <= 1'b0;
		end
	end

	udbp_crc u_crc (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (crc_clear),
		.en       (crc_en),
		.data     (crc_word),
		.crc_r    (crc_val)
	);

	udbp_buf #(.WIDTH(16), .DEPTH(2)) u_tx_buf (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (tx_valid),
		.in_data   (tx_data),
		.in_ready  (tx_ready),
		.out_valid (tx_out_valid),
		.out_data  (tx_out_data),
		.out_ready (tx_pop)
	);

	// rx side: ready to host only while buffer head is empty
	assign rx_has_word = rx_valid;

	udbp_buf #(.WIDTH(16), .DEPTH(2)) u_rx_buf (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (rx_push_r),
		.in_data   (rx_word_r),
		.in_ready  (rx_in_ready),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready)
	);
endmodule : udbp_port
`default_nettype wire

// ===== udbp_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module udbp_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic [1:0]  iface_mode,
	input wire logic        host_attribute_select_line,
	input wire logic        device_wait_line_oe,
	input wire logic        host_data_bus_oe,
	input wire logic [10:0] host_address_bus,
	input wire logic [10:0] decoded_addr_r,
	input wire logic        input_acknowledge_pin_o,
	input wire logic        input_acknowledge_pin_level,
	input wire logic        feat_valid,
	input wire logic [7:0]  feat_code,
	input wire logic        udma_sel_r,
	input wire logic [2:0]  udma_mode_r,
	input wire logic        mwdma_sel_r,
	input wire logic        feat_reject_r,
	input wire logic [15:0] id_udma_word_r,
	input wire logic        crc_err_r,
	input wire logic        cmd_abort_r
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// pin meanings, ownership and release
	chk_ide_addr_mask: assert property (iface_mode == udbp_pkg::IFM_IDE |=>
		decoded_addr_r == {8'h00, $past(host_address_bus[2:0])}) else $error("ide addr");
	chk_ack_release_pins: assert property (host_attribute_select_line [*6] |=>
		!device_wait_line_oe && !host_data_bus_oe) else $error("pins kept after ack");
	chk_data_owner_strobe: assert property (host_data_bus_oe |-> device_wait_line_oe)
		else $error("data without strobe");
	chk_pin_plain: assert property ($past(rst_n) && !$past(udma_sel_r) && !udma_sel_r
		|-> input_acknowledge_pin_o == $past(input_acknowledge_pin_level)) else $error("pin not plain");
	// mode selection and reporting
	chk_udma_take: assert property (feat_valid && feat_code[7:3] == 5'h08
		&& feat_code[2:0] != 3'h7 |=> udma_sel_r && udma_mode_r == $past(feat_code[2:0]))
		else $error("udma mode not taken");
	chk_mode_refuse: assert property (feat_valid && feat_code == 8'h47 |=> feat_reject_r)
		else $error("fast mode not refused");
	chk_one_mode: assert property (!(udma_sel_r && mwdma_sel_r))
		else $error("two modes active");
	chk_id_word: assert property ($past(udma_sel_r) |-> id_udma_word_r ==
		{1'b0, 7'(8'h01 << $past(udma_mode_r)), 8'h7F}) else $error("id word");
	chk_hw_reset: assert property ($rose(rst_n) |-> !udma_sel_r && !mwdma_sel_r
		&& id_udma_word_r == 16'h007F) else $error("reset leaves mode");
	chk_abort_err_pulse: assert property (cmd_abort_r |-> crc_err_r ##1 !cmd_abort_r)
		else $error("abort without error");

	cover property (udma_sel_r && udma_mode_r == 3'h6);
	cover property (host_data_bus_oe);
	cover property (cmd_abort_r);
endmodule : udbp_chk

bind udbp_port udbp_chk udbp_chk_i (.core_clk, .rst_n, .iface_mode,
	.host_attribute_select_line, .device_wait_line_oe, .host_data_bus_oe,
	.host_address_bus, .decoded_addr_r, .input_acknowledge_pin_o, .input_acknowledge_pin_level,
	.feat_valid, .feat_code, .udma_sel_r, .udma_mode_r, .mwdma_sel_r, .feat_reject_r,
	.id_udma_word_r, .crc_err_r, .cmd_abort_r);
`default_nettype wire

// ===== udbp_host.sv
`timescale 1ns/1ps
`default_nettype none
module udbp_host (
	input  wire logic        core_clk,
	input  wire logic        ide,
	input  wire logic        dmarq_pin,
	input  wire logic        wait_o,
	input  wire logic        wait_oe,
	input  wire logic [15:0] dev_data,
	output logic             dmack_n,
	output logic             stop,
	output logic             hoe,
	output logic      [15:0] hd
);
	logic [15:0] rq[$];
	logic [15:0] wq[$];
	logic [15:0] crc;
	logic        got_req;
	logic        wline;

	// released wait line is pulled up by the host
	assign wline = wait_oe ? wait_o : 1'b1;

	// idle host control pins sit high, data bus at zero
	initial
	begin
		dmack_n = 1'b1;
		stop = 1'b1;
		hoe = 1'b1;
		hd = 16'h0000;
		got_req = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? udbp_pkg::CRC_POLY : 16'h0000);
		return c;
	endfunction : crc_step

	// acknowledge only a request asserted in this mode's polarity
	task automatic start_burst();
		got_req = 1'b0;
		crc = udbp_pkg::CRC_SEED;
		for (int t = 0; t < 200 && !got_req; t++)
		begin
			step(1);
			got_req = (dmarq_pin == ide);
		end
		if (got_req)
			dmack_n = 1'b0;
		stop = !got_req;
	endtask : start_burst

	// crc stays on the bus across the acknowledge negation
	task automatic end_burst(input logic bad);
		step(8);
		stop = 1'b1;
		hd = crc ^ {15'h0000, bad};
		step(4);
		dmack_n = 1'b1;
		step(6);
		hd = ~hd;
		hoe = 1'b1;
	endtask : end_burst

	// read: latch a word on every device strobe edge
	task automatic rd_burst(input int n, input logic bad);
		logic last;
		last = 1'b1;
		start_burst();
		if (!got_req)
			return;
		hoe = 1'b0;
		for (int t = 0; t < 400 && rq.size() < n; t++)
		begin
			step(1);
			if (wait_oe && wline != last)
			begin
				rq.push_back(dev_data);
				crc = crc_step(crc, dev_data);
			end
			last = wline;
		end
		hoe = 1'b1;
		end_burst(bad);
	endtask : rd_burst

	// write: data settles 40 ns each side of a strobe edge
	task automatic wr_burst(input logic bad);
		start_burst();
		if (!got_req)
			return;
		while (wq.size() > 0)
		begin
			for (int t = 0; t < 400 && wline; t++)
				step(1);
			hd = wq.pop_front();
			crc = crc_step(crc, hd);
			step(4);
			hoe = ~hoe;
			step(4);
		end
		end_burst(bad);
	endtask : wr_burst
endmodule : udbp_host
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  iface_mode = udbp_pkg::IFM_IDE;
	logic [10:0] host_address_bus = 11'h000;
	logic        input_acknowledge_pin_level = 1'b0;
	logic        feat_valid = 1'b0;
	logic [7:0]  feat_code = 8'h00;
	logic        revert_en_set = 1'b0;
	logic        revert_dis_set = 1'b0;
	logic        soft_reset = 1'b0;
	logic        cmd_start = 1'b0;
	logic        cmd_write = 1'b0;
	logic        cmd_done = 1'b0;
	logic        crc_abort_en = 1'b0;
	logic        tx_valid = 1'b0;
	logic [15:0] tx_data = 16'h0000;
	logic        rx_ready = 1'b1;
	logic        host_attribute_select_line, host_write_strobe_line, host_output_enable_line;
	logic        device_wait_line_o, device_wait_line_oe, host_data_bus_oe, tx_ready;
	logic        input_acknowledge_pin_o, rx_valid, udma_sel_r, mwdma_sel_r;
	logic        feat_reject_r, crc_err_r, cmd_abort_r, burst_active_r;
	logic [15:0] host_data_bus_o, hd_host, hd_wire, rx_data, id_udma_word_r;
	logic [10:0] decoded_addr_r;
	logic [7:0]  crc_err_burst_r;
	logic [2:0]  udma_mode_r, mwdma_mode_r;
	int          miscompares = 0;
	int          n_tests = 0;

	// bus level seen by the device: its own drive, else the host's
	assign hd_wire = host_data_bus_oe ? host_data_bus_o : hd_host;

	udbp_port udbp_port_i (.core_clk, .rst_n, .iface_mode, .host_attribute_select_line,
		.host_write_strobe_line, .host_output_enable_line, .device_wait_line_o,
		.device_wait_line_oe, .host_data_bus_i(hd_wire), .host_data_bus_o, .host_data_bus_oe,
		.host_address_bus, .decoded_addr_r, .input_acknowledge_pin_o, .input_acknowledge_pin_level,
		.feat_valid, .feat_code, .revert_en_set, .revert_dis_set, .soft_reset, .cmd_start,
		.cmd_write, .cmd_done, .crc_abort_en, .tx_valid, .tx_data, .tx_ready, .rx_valid,
		.rx_data, .rx_ready, .udma_sel_r, .udma_mode_r, .mwdma_sel_r, .mwdma_mode_r,
		.feat_reject_r, .id_udma_word_r, .crc_err_r, .crc_err_burst_r, .cmd_abort_r,
		.burst_active_r);

	udbp_host udbp_host_i (.core_clk, .ide(iface_mode == udbp_pkg::IFM_IDE),
		.dmarq_pin(input_acknowledge_pin_o), .wait_o(device_wait_line_o),
		.wait_oe(device_wait_line_oe), .dev_data(host_data_bus_o),
		.dmack_n(host_attribute_select_line), .stop(host_write_strobe_line),
		.hoe(host_output_enable_line), .hd(hd_host));

	// 100 MHz clock
	always #5 core_clk = ~core_clk;

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	task automatic feat(input logic [7:0] c);
		feat_code = c;
		pulse(feat_valid);
	endtask : feat

	task automatic t_modes();
		for (int n = 0; n <= udbp_pkg::UDMA_MAX; n++)
		begin
			feat(8'h40 + 8'(n));
			check("udma", {11'h000, feat_reject_r, udma_sel_r, udma_mode_r}, 16'h0008 | 16'(n));
			tick(1);
			check("id_word", id_udma_word_r, 16'h007F | (16'h0100 << n));
		end
		feat(8'h47);
		check("refuse", {12'h000, feat_reject_r, udma_mode_r}, 16'h000E);
		tick(1);
		feat(8'h22);
		check("one_mode", {14'h0000, udma_sel_r, mwdma_sel_r}, 16'h0001);
		check("mw_mode", {13'h0000, mwdma_mode_r}, 16'h0002);
		tick(1);
	endtask : t_modes

	task automatic t_revert();
		feat(8'h45);
		pulse(revert_dis_set);
		pulse(soft_reset);
		check("kept", {12'h000, udma_sel_r, udma_mode_r}, 16'h000D);
		pulse(revert_en_set);
		pulse(soft_reset);
		check("revert", {14'h0000, udma_sel_r, mwdma_sel_r}, 16'h0001);
		cmd_write = 1'b0;
		pulse(cmd_start);
		udbp_host_i.start_burst();
		check("no_req", {15'h0000, udbp_host_i.got_req}, 16'h0000);
		pulse(cmd_done);
		feat(8'h45);
		rst_n = 1'b0;
		tick(20);
		rst_n = 1'b1;
		tick(1);
		check("hw_reset", {udma_sel_r, mwdma_sel_r, id_udma_word_r[13:0]}, 16'h007F);
	endtask : t_revert

	task automatic t_addr();
		feat(8'h42);
		host_address_bus = 11'h7FD;
		tick(2);
		check("ide_addr", {5'h00, decoded_addr_r}, 16'h0005);
		check("req_ide", {15'h0000, input_acknowledge_pin_o}, 16'h0000);
		iface_mode = udbp_pkg::IFM_MEM;
		input_acknowledge_pin_level = 1'b1;
		tick(2);
		check("mem_addr", {5'h00, decoded_addr_r}, 16'h07FD);
		check("req_mem", {15'h0000, input_acknowledge_pin_o}, 16'h0001);
		iface_mode = udbp_pkg::IFM_IDE;
		input_acknowledge_pin_level = 1'b0;
		tick(2);
	endtask : t_addr

	task automatic t_read();
		logic [15:0] w[5];
		w = '{16'h1234, 16'hFFFF, 16'h0000, 16'hA5C3, 16'h8001};
		cmd_write = 1'b0;
		pulse(cmd_start);
		fork
			udbp_host_i.rd_burst(5, 1'b0);
			begin
				foreach (w[i])
				begin
					tx_data = w[i];
					tx_valid = 1'b1;
					for (int t = 0; t < 300 && !tx_ready; t++)
						tick(1);
					tick(1);
				end
				tx_valid = 1'b0;
			end
		join
		tick(6);
		foreach (w[i])
			check("rd_word", udbp_host_i.rq[i], w[i]);
		check("rd_end", {14'h0000, crc_err_r, host_data_bus_oe}, 16'h0000);
		pulse(cmd_done);
	endtask : t_read

	task automatic t_write();
		logic [15:0] got[$];
		logic [15:0] w[6];
		w = '{16'h0001, 16'h8000, 16'hFFFE, 16'h5A5A, 16'h0F0F, 16'hC3C3};
		cmd_write = 1'b1;
		pulse(cmd_start);
		foreach (w[i])
			udbp_host_i.wq.push_back(w[i]);
		fork
			udbp_host_i.wr_burst(1'b0);
			for (int t = 0; t < 3000 && got.size() < 6; t++)
			begin
				rx_ready = (t >= 80);
				if (t == 79)
					check("stall", {14'h0000, burst_active_r, device_wait_line_o}, 16'h0003);
				if (rx_valid === 1'b1 && rx_ready)
					got.push_back(rx_data);
				tick(1);
			end
		join
		tick(6);
		foreach (w[i])
			check("wr_word", got[i], w[i]);
		check("wr_crc", {15'h0000, crc_err_r}, 16'h0000);
		pulse(cmd_done);
	endtask : t_write

	task automatic t_crc();
		logic ab;
		ab = 1'b0;
		pulse(cmd_start);
		udbp_host_i.wq = '{16'h1111};
		udbp_host_i.wr_burst(1'b1);
		tick(6);
		check("crc_err", {7'h00, crc_err_r, crc_err_burst_r}, 16'h0100);
		udbp_host_i.wq = '{16'h2222};
		udbp_host_i.wr_burst(1'b1);
		tick(6);
		check("first_err", {7'h00, crc_err_r, crc_err_burst_r}, 16'h0100);
		pulse(cmd_done);
		crc_abort_en = 1'b1;
		pulse(cmd_start);
		udbp_host_i.wq = '{16'h3333};
		fork
			udbp_host_i.wr_burst(1'b1);
			for (int t = 0; t < 300; t++)
			begin
				ab |= (cmd_abort_r === 1'b1);
				tick(1);
			end
		join
		check("abort", {14'h0000, ab, crc_err_r}, 16'h0003);
		pulse(cmd_done);
	endtask : t_crc

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// watchdog: about twenty times the expected run
	initial
	begin
		#200000;
		miscompares++;
		close_out();
	end

	// main sequence
	initial
	begin
		tick(20);
		rst_n = 1'b1;
		tick(3);
		t_modes();
		t_revert();
		t_addr();
		t_read();
		t_write();
		t_crc();
		close_out();
	end
endmodule : testbench
`default_nettype wire
